// >>> src/parity_diag_defines.vh
// register offsets, field positions and sizes for the parity and fifo diagnostic block
`ifndef PARITY_DIAG_DEFINES_VH
`define PARITY_DIAG_DEFINES_VH

`define OFF_SCSI_CONTROL_FIRST   12'h000
`define OFF_SCSI_CONTROL_SECOND  12'h004
`define OFF_TRANSFER_CONFIG      12'h008
`define OFF_SCSI_IRQ_ENABLE      12'h00C
`define OFF_SCSI_STATUS_FIRST    12'h010
`define OFF_SCSI_STATUS_SECOND   12'h014
`define OFF_SCSI_STATUS_THIRD    12'h018
`define OFF_DIAG_STATUS          12'h01C
`define OFF_SCSI_FIFO_READ_PORT  12'h020
`define OFF_FIFO_TEST_CONTROL    12'h024
`define OFF_DMA_FIFO_DATA_PORT   12'h028
`define OFF_DMA_FIFO_PARITY_WR   12'h02C
`define OFF_SCSI_OUTPUT_LATCH    12'h030
`define OFF_SCSI_INPUT_LATCH     12'h034

`define BIT_ASSERT_ATN           1
`define BIT_PARITY_GEN_EN        2
`define BIT_PARITY_CHECK_EN      3
`define BIT_EVEN_PARITY_SEL      2
`define BIT_HALT_ON_PARITY       7
`define BIT_PARITY_IRQ_EN        0
`define BIT_PARITY_ERROR         0
`define BIT_LIVE_SCSI_PARITY     0
`define BIT_LATCHED_PARITY       3
`define BIT_DMA_FIFO_PARITY      3
`define BIT_SCSI_FIFO_PARITY     4
`define BIT_SCSI_FIFO_WR_EN      3
`define BIT_LANE_ACCESS_EN       2

`define DMA_LANE_DEPTH           16
`define DMA_LANE_PTR_W           4
`define SCSI_FIFO_DEPTH          8
`define SCSI_FIFO_PTR_W          3

`endif

// >>> src/scsi_parity_fifo_diag.v
// parity control, error reporting and fifo diagnostic access over apb
//
// Operation
// - even select sets checking and generating sense
// - halt control stops target on parity error
// - parity interrupt only when enable set
// - parity error status set on any error
// - live scsi parity line visible unlatched
// - latched parity of captured input byte
// - dma fifo read copies stored parity
// - write-only bit supplies dma fifo parity
// - scsi fifo read captures popped parity
// - checking disabled means no parity errors
// - generation off: parity flows both ways
// - generation on: generate, never drive host
// - interrupt any mode, halt target only
// - dma fifo four lanes, sixteen deep
// - write top, read bottom, fifo order
// - lane select field, top bit enables
// - write enable lets output latch push
// - generation off: parity from host lane
// - generation on: store selected sense parity
// - generate and check at bits 2,3
// - initiator parity error asserts attention
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "parity_diag_defines.vh"

module scsi_parity_fifo_diag (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [3:0]  host_parity_lanes_in,
    output reg  [3:0]  host_parity_lanes_out,
    output reg  [3:0]  host_parity_lanes_oe,
    input  wire [31:0] host_data_in,
    input  wire        host_send_valid,
    input  wire [1:0]  host_send_lane,
    output reg  [7:0]  scsi_data_out,
    output reg         scsi_parity_line_out,
    output reg         scsi_parity_line_oe,
    input  wire [7:0]  scsi_data_in,
    input  wire        scsi_parity_line_in,
    input  wire        scsi_recv_strobe,
    input  wire        target_mode,
    output reg         scsi_atn_out,
    output reg         halt_target,
    output wire        parity_irq
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [7:0] sd_meta_reg;
    reg [7:0] sd_sync_reg;
    reg [2:0] sp_meta_reg;
    reg [2:0] sp_sync_reg;
    reg [2:0] sp_prev_reg;
    reg [3:0] hp_meta_reg;
    reg [3:0] hp_sync_reg;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sd_meta_reg <= 8'h00;
            sd_sync_reg <= 8'h00;
            sp_meta_reg <= 3'h0;
            sp_sync_reg <= 3'h0;
            sp_prev_reg <= 3'h0;
            hp_meta_reg <= 4'h0;
            hp_sync_reg <= 4'h0;
        end else begin
            sd_meta_reg <= scsi_data_in;
            sd_sync_reg <= sd_meta_reg;
            sp_meta_reg <= {scsi_recv_strobe, target_mode, scsi_parity_line_in};
            sp_sync_reg <= sp_meta_reg;
            sp_prev_reg <= sp_sync_reg;
            hp_meta_reg <= host_parity_lanes_in;
            hp_sync_reg <= hp_meta_reg;
        end
    end

    wire scsi_par_live = sp_sync_reg[0];
    wire tgt_mode      = sp_sync_reg[1];
    // strobe edge seen in the first cycle its synchronised level is high, data synchronised to the same depth
    wire recv_pulse    = sp_sync_reg[2] & ~sp_prev_reg[2];

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    reg [7:0] ctrl_first_reg;
    reg [7:0] ctrl_second_reg;
    reg [7:0] xfer_cfg_reg;
    reg [7:0] irq_en_reg;
    reg [7:0] test_ctrl_reg;
    reg       dma_par_wr_reg;

    wire gen_en   = ctrl_first_reg[`BIT_PARITY_GEN_EN];
    wire chk_en   = ctrl_first_reg[`BIT_PARITY_CHECK_EN];
    wire atn_en   = ctrl_first_reg[`BIT_ASSERT_ATN];
    wire even_sel = ctrl_second_reg[`BIT_EVEN_PARITY_SEL];
    wire halt_en  = xfer_cfg_reg[`BIT_HALT_ON_PARITY];
    wire irq_en   = irq_en_reg[`BIT_PARITY_IRQ_EN];
    wire lane_access_enable = test_ctrl_reg[`BIT_LANE_ACCESS_EN];
    wire [1:0] lane_sel = test_ctrl_reg[1:0];
    wire sfifo_wr_en = test_ctrl_reg[`BIT_SCSI_FIFO_WR_EN];

    wire access = psel & penable;
    wire wr     = access & pwrite;
    wire rd     = access & ~pwrite;
    assign pready = 1'b1;

    reg addr_ok;
    always @* begin
        case (paddr)
            `OFF_SCSI_CONTROL_FIRST, `OFF_SCSI_CONTROL_SECOND,
            `OFF_TRANSFER_CONFIG, `OFF_SCSI_IRQ_ENABLE,
            `OFF_SCSI_STATUS_FIRST, `OFF_SCSI_STATUS_SECOND,
            `OFF_SCSI_STATUS_THIRD, `OFF_DIAG_STATUS,
            `OFF_SCSI_FIFO_READ_PORT, `OFF_FIFO_TEST_CONTROL,
            `OFF_DMA_FIFO_DATA_PORT, `OFF_DMA_FIFO_PARITY_WR,
            `OFF_SCSI_OUTPUT_LATCH, `OFF_SCSI_INPUT_LATCH: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = access & ~addr_ok;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_first_reg  <= 8'h00;
            ctrl_second_reg <= 8'h00;
            xfer_cfg_reg    <= 8'h00;
            irq_en_reg      <= 8'h00;
            test_ctrl_reg   <= 8'h00;
            dma_par_wr_reg  <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `OFF_SCSI_CONTROL_FIRST:  ctrl_first_reg  <= pwdata[7:0];
                `OFF_SCSI_CONTROL_SECOND: ctrl_second_reg <= pwdata[7:0];
                `OFF_TRANSFER_CONFIG:     xfer_cfg_reg    <= pwdata[7:0];
                `OFF_SCSI_IRQ_ENABLE:     irq_en_reg      <= pwdata[7:0];
                `OFF_FIFO_TEST_CONTROL:   test_ctrl_reg   <= pwdata[7:0];
                // held until rewritten; software refreshes it per write
                `OFF_DMA_FIFO_PARITY_WR:  dma_par_wr_reg  <= pwdata[`BIT_DMA_FIFO_PARITY];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // parity functions
    // ------------------------------------------------------------
    // odd sense: byte plus parity has odd ones count
    function gen_par;
        input [7:0] d;
        input       ev;
        begin
            gen_par = ev ? (^d) : ~(^d);
        end
    endfunction

    // ------------------------------------------------------------
    // dma fifo: four lanes of sixteen nine-bit entries
    // ------------------------------------------------------------
    wire dma_wr = wr & lane_access_enable & (paddr == `OFF_DMA_FIFO_DATA_PORT);
    wire dma_rd = rd & lane_access_enable & (paddr == `OFF_DMA_FIFO_DATA_PORT);
    wire [8:0] lane_head [0:3];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            reg [8:0] mem [0:`DMA_LANE_DEPTH-1];
            reg [`DMA_LANE_PTR_W:0] wp_reg;
            reg [`DMA_LANE_PTR_W:0] rp_reg;
            wire sel  = (lane_sel == g);
            wire full = (wp_reg[`DMA_LANE_PTR_W] != rp_reg[`DMA_LANE_PTR_W]) &&
                        (wp_reg[`DMA_LANE_PTR_W-1:0] == rp_reg[`DMA_LANE_PTR_W-1:0]);
            wire emp  = (wp_reg == rp_reg);
            always @(posedge core_clk) begin
                if (dma_wr & sel & ~full) begin
                    mem[wp_reg[`DMA_LANE_PTR_W-1:0]] <= {dma_par_wr_reg, pwdata[7:0]};
                end
            end
            always @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    wp_reg <= 5'h00;
                    rp_reg <= 5'h00;
                end else begin
                    if (dma_wr & sel & ~full) begin
                        wp_reg <= wp_reg + 5'h01;
                    end
                    if (dma_rd & sel & ~emp) begin
                        rp_reg <= rp_reg + 5'h01;
                    end
                end
            end
            assign lane_head[g] = mem[rp_reg[`DMA_LANE_PTR_W-1:0]];
        end
    endgenerate

    wire [8:0] dma_head = lane_head[lane_sel];

    // ------------------------------------------------------------
    // scsi fifo, loaded through the output latch in test
    // ------------------------------------------------------------
    reg [8:0] sfifo_mem [0:`SCSI_FIFO_DEPTH-1];
    reg [`SCSI_FIFO_PTR_W:0] swp_reg;
    reg [`SCSI_FIFO_PTR_W:0] srp_reg;
    wire sfifo_empty = (swp_reg == srp_reg);
    wire sfifo_full  = (swp_reg[`SCSI_FIFO_PTR_W] != srp_reg[`SCSI_FIFO_PTR_W]) &&
                       (swp_reg[`SCSI_FIFO_PTR_W-1:0] == srp_reg[`SCSI_FIFO_PTR_W-1:0]);
    wire odl_wr  = wr & (paddr == `OFF_SCSI_OUTPUT_LATCH);
    wire s_push  = odl_wr & sfifo_wr_en & ~sfifo_full;
    wire s_pop   = rd & (paddr == `OFF_SCSI_FIFO_READ_PORT) & ~sfifo_empty;
    // host parity lane 0 is always used, whatever the latch's byte lane
    // every input passed in, so the assign re-evaluates on any change
    wire load_par = gen_par_sel(pwdata[7:0], gen_en, even_sel, hp_sync_reg[0]);

    function gen_par_sel;
        input [7:0] d;
        input       ge;
        input       ev;
        input       hp;
        begin
            if (ge) begin
                gen_par_sel = gen_par(d, ev);
            end else begin
                gen_par_sel = hp;
            end
        end
    endfunction

    always @(posedge core_clk) begin
        if (s_push) begin
            sfifo_mem[swp_reg[`SCSI_FIFO_PTR_W-1:0]] <= {load_par, pwdata[7:0]};
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            swp_reg <= 4'h0;
            srp_reg <= 4'h0;
        end else begin
            if (s_push) begin
                swp_reg <= swp_reg + 4'h1;
            end
            if (s_pop) begin
                srp_reg <= srp_reg + 4'h1;
            end
        end
    end

    wire [8:0] sfifo_head = sfifo_mem[srp_reg[`SCSI_FIFO_PTR_W-1:0]];

    // ------------------------------------------------------------
    // send and receive paths, error detection
    // ------------------------------------------------------------
    reg [7:0] odl_reg;
    reg       odl_par_reg;
    reg [8:0] idl_reg;
    reg       dma_par_rd_reg;
    reg       sfifo_par_rd_reg;
    reg       par_err_reg;
    reg       irq_reg;

    wire [7:0] send_byte = host_data_in[{host_send_lane, 3'b000} +: 8];
    wire       send_host_par = hp_sync_reg[host_send_lane];
    wire       send_bad = send_host_par != gen_par(send_byte, even_sel);
    wire       recv_bad = sp_sync_reg[0] != gen_par(sd_sync_reg, even_sel);
    // system side checked on outgoing data, scsi side on received data
    wire err_evt = chk_en & ((host_send_valid & send_bad) | (recv_pulse & recv_bad));

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            odl_reg          <= 8'h00;
            odl_par_reg      <= 1'b0;
            idl_reg          <= 9'h000;
            dma_par_rd_reg   <= 1'b0;
            sfifo_par_rd_reg <= 1'b0;
            par_err_reg      <= 1'b0;
            halt_target      <= 1'b0;
            scsi_atn_out     <= 1'b0;
        end else begin
            if (host_send_valid) begin
                odl_reg     <= send_byte;
                odl_par_reg <= gen_en ? gen_par(send_byte, even_sel) : send_host_par;
            end
            if (recv_pulse) begin
                idl_reg <= {scsi_par_live, sd_sync_reg};
            end
            if (dma_rd) begin
                dma_par_rd_reg <= dma_head[8];
            end
            if (s_pop) begin
                sfifo_par_rd_reg <= sfifo_head[8];
            end
            // set wins over read-clear in the same cycle
            if (err_evt) begin
                par_err_reg <= 1'b1;
            end else if (rd & (paddr == `OFF_SCSI_STATUS_FIRST)) begin
                par_err_reg <= 1'b0;
            end
            if (err_evt & halt_en & tgt_mode) begin
                halt_target <= 1'b1;
            end else if (wr & (paddr == `OFF_TRANSFER_CONFIG)) begin
                halt_target <= 1'b0;
            end
            if (err_evt & atn_en & ~tgt_mode) begin
                scsi_atn_out <= 1'b1;
            end else if (wr & (paddr == `OFF_SCSI_CONTROL_FIRST)) begin
                scsi_atn_out <= 1'b0;
            end
        end
    end

    // interrupt independent of halt and of mode
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= (par_err_reg | err_evt) & irq_en;
        end
    end
    assign parity_irq = irq_reg;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scsi_data_out         <= 8'h00;
            scsi_parity_line_out  <= 1'b0;
            scsi_parity_line_oe   <= 1'b0;
            host_parity_lanes_out <= 4'h0;
            host_parity_lanes_oe  <= 4'h0;
        end else begin
            scsi_data_out        <= odl_reg;
            scsi_parity_line_out <= odl_par_reg;
            scsi_parity_line_oe  <= 1'b1;
            host_parity_lanes_out <= {4{idl_reg[8]}};
            // received parity only reaches the host in flow-through
            host_parity_lanes_oe  <= gen_en ? 4'h0 : 4'hF;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always @* begin
        prdata = 32'h0000_0000;
        case (paddr)
            `OFF_SCSI_CONTROL_FIRST:  prdata[7:0] = ctrl_first_reg;
            `OFF_SCSI_CONTROL_SECOND: prdata[7:0] = ctrl_second_reg;
            `OFF_TRANSFER_CONFIG:     prdata[7:0] = xfer_cfg_reg;
            `OFF_SCSI_IRQ_ENABLE:     prdata[7:0] = irq_en_reg;
            `OFF_SCSI_STATUS_FIRST:   prdata[`BIT_PARITY_ERROR] = par_err_reg;
            `OFF_SCSI_STATUS_SECOND:  prdata[`BIT_LIVE_SCSI_PARITY] = scsi_par_live;
            `OFF_SCSI_STATUS_THIRD:   prdata[`BIT_LATCHED_PARITY] = idl_reg[8];
            `OFF_DIAG_STATUS: begin
                prdata[`BIT_DMA_FIFO_PARITY]  = dma_par_rd_reg;
                prdata[`BIT_SCSI_FIFO_PARITY] = sfifo_par_rd_reg;
            end
            `OFF_SCSI_FIFO_READ_PORT: prdata[7:0] = sfifo_head[7:0];
            `OFF_FIFO_TEST_CONTROL:   prdata[7:0] = test_ctrl_reg;
            `OFF_DMA_FIFO_DATA_PORT:  prdata[7:0] = lane_access_enable ? dma_head[7:0] : 8'h00;
            `OFF_SCSI_OUTPUT_LATCH:   prdata[7:0] = odl_reg;
            `OFF_SCSI_INPUT_LATCH:    prdata[7:0] = idl_reg[7:0];
            default:                  prdata = 32'h0000_0000;
        endcase
    end

endmodule // scsi_parity_fifo_diag

// >>> tb/parity_diag_sva.sv
// assertions on the ports of the parity and fifo diagnostic block
`timescale 1ns/1ps
`include "parity_diag_defines.vh"
module parity_diag_sva (
    input wire        core_clk,
    input wire        sys_rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [3:0]  host_parity_lanes_in,
    input wire [3:0]  host_parity_lanes_out,
    input wire [3:0]  host_parity_lanes_oe,
    input wire [31:0] host_data_in,
    input wire        host_send_valid,
    input wire [1:0]  host_send_lane,
    input wire [7:0]  scsi_data_out,
    input wire        scsi_parity_line_out,
    input wire        target_mode,
    input wire        scsi_atn_out,
    input wire        halt_target,
    input wire        parity_irq
);
// --------------------------------
// control shadows
// --------------------------------
reg       gen_q, chk_q, even_q, atn_q, halt_q, irq_q;
reg [1:0] up_q;
wire       wr = psel && penable && pwrite && pready;
wire [7:0] sb = host_data_in[host_send_lane*8 +: 8];
wire       sp = host_parity_lanes_in[host_send_lane];
wire       gp = even_q ? ^sb : ~^sb;
always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
        {gen_q, chk_q, even_q, atn_q, halt_q, irq_q, up_q} <= 8'h00;
    end else begin
        if (up_q != 2'h3) up_q <= up_q + 2'h1;
        if (wr && paddr == `OFF_SCSI_CONTROL_FIRST) {chk_q, gen_q, atn_q} <= pwdata[3:1];
        if (wr && paddr == `OFF_SCSI_CONTROL_SECOND) even_q <= pwdata[2];
        if (wr && paddr == `OFF_TRANSFER_CONFIG) halt_q <= pwdata[7];
        if (wr && paddr == `OFF_SCSI_IRQ_ENABLE) irq_q <= pwdata[0];
    end
end
// --------------------------------
// properties
// --------------------------------
default clocking cb @(posedge core_clk); endclocking
default disable iff (sys_rst);
a_oe_follow_gen: assert property (up_q == 2'h3 && $stable(gen_q) |-> host_parity_lanes_oe == {4{!gen_q}})
    else $error("host lane enable wrong");
a_irq_needs_en: assert property (parity_irq |-> $past(irq_q))
    else $error("irq without enable");
a_halt_cause: assert property ($rose(halt_target) |-> $past(halt_q) && $past(chk_q) && target_mode)
    else $error("halt without cause");
a_atn_cause: assert property ($rose(scsi_atn_out) |-> $past(atn_q) && $past(chk_q) && !target_mode)
    else $error("attention without cause");
a_send_data: assert property (host_send_valid |=> ##1 scsi_data_out == $past(sb, 2))
    else $error("send byte wrong");
a_send_flow: assert property (host_send_valid && !gen_q && host_parity_lanes_in == $past(host_parity_lanes_in, 2) |=> ##1 scsi_parity_line_out == $past(sp, 2))
    else $error("flow parity wrong");
a_send_gen: assert property (host_send_valid && gen_q |=> ##1 scsi_parity_line_out == $past(gp, 2))
    else $error("generated parity wrong");
a_lanes_same: assert property (host_parity_lanes_out == {4{host_parity_lanes_out[0]}})
    else $error("host lanes differ");
endmodule // parity_diag_sva
bind scsi_parity_fifo_diag parity_diag_sva sva_u (.core_clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .host_parity_lanes_in, .host_parity_lanes_out, .host_parity_lanes_oe,
    .host_data_in, .host_send_valid, .host_send_lane, .scsi_data_out, .scsi_parity_line_out,
    .target_mode, .scsi_atn_out, .halt_target, .parity_irq);

// >>> tb/scsi_bus_model.sv
// scsi device model that sends bytes into the block
`timescale 1ns/1ps
module scsi_bus_model (
    input  wire       core_clk,
    output reg  [7:0] scsi_data_in,
    output reg        scsi_parity_line_in,
    output reg        scsi_recv_strobe
);
initial begin
    scsi_data_in = 8'h00;
    scsi_parity_line_in = 1'b0;
    scsi_recv_strobe = 1'b0;
end
// released lines show the inverse, so a stale value never passes
task send_byte(input [7:0] d, input p);
    begin
        @(posedge core_clk);
        scsi_data_in <= d;
        scsi_parity_line_in <= p;
        repeat (3) @(posedge core_clk);
        scsi_recv_strobe <= 1'b1;
        repeat (4) @(posedge core_clk);
        scsi_recv_strobe <= 1'b0;
        repeat (3) @(posedge core_clk);
        scsi_data_in <= ~d;
        scsi_parity_line_in <= ~p;
    end
endtask
endmodule // scsi_bus_model

// >>> tb/testbench.sv
// self-checking bench for the parity and fifo diagnostic block
`timescale 1ns/1ps
`include "parity_diag_defines.vh"
module testbench;
reg         core_clk = 1'b0;
reg         sys_rst = 1'b1;
reg         psel = 1'b0;
reg         penable = 1'b0;
reg         pwrite = 1'b0;
reg  [11:0] paddr = 12'h000;
reg  [31:0] pwdata = 32'h00000000;
reg  [3:0]  host_parity_lanes_in = 4'h0;
reg  [31:0] host_data_in = 32'h00000000;
reg         host_send_valid = 1'b0;
reg  [1:0]  host_send_lane = 2'h0;
reg         target_mode = 1'b0;
wire [31:0] prdata;
wire        pready, pslverr, scsi_parity_line_out, scsi_parity_line_oe;
wire        scsi_atn_out, halt_target, parity_irq, scsi_parity_line_in, scsi_recv_strobe;
wire [3:0]  host_parity_lanes_out, host_parity_lanes_oe;
wire [7:0]  scsi_data_out, scsi_data_in;
integer     failures = 0;
integer     comparisons = 0;
reg  [64:0] exp_q[$];
reg  [64:0] e;
always #50 core_clk = ~core_clk;
scsi_parity_fifo_diag dut_u (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .host_parity_lanes_in, .host_parity_lanes_out,
    .host_parity_lanes_oe, .host_data_in, .host_send_valid, .host_send_lane, .scsi_data_out,
    .scsi_parity_line_out, .scsi_parity_line_oe, .scsi_data_in, .scsi_parity_line_in,
    .scsi_recv_strobe, .target_mode, .scsi_atn_out, .halt_target, .parity_irq);
scsi_bus_model scsi_u (.core_clk, .scsi_data_in, .scsi_parity_line_in, .scsi_recv_strobe);
// --------------------------------
// shared tasks
// --------------------------------
task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    end
endtask
task results;
    begin
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    end
endtask
task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge core_clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    end
endtask
task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
endtask
// unmapped offsets above the last register expect an error answer
task rd(input [11:0] a, input [31:0] m, input [31:0] x);
    begin
        exp_q.push_back({a > `OFF_SCSI_INPUT_LATCH, m, x});
        apb(1'b0, a, 32'h00000000);
    end
endtask
always @(posedge core_clk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        check("prdata", prdata & e[63:32], e[31:0]);
        check("pslverr", {31'h0, pslverr}, {31'h0, e[64]});
    end
end
task pulse_send(input [31:0] x, input [1:0] l);
    begin
        host_data_in <= x;
        host_send_lane <= l;
        host_send_valid <= 1'b1;
        @(posedge core_clk);
    end
endtask
// --------------------------------
// tests
// --------------------------------
initial begin : main
    reg [11:0] i, l, g, v;
    reg [7:0]  d [0:63];
    reg        p [0:63];
    reg [31:0] x;
    reg [31:0] s;
    reg        f;
    x = $urandom(32'h49F7);
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 8; i = i + 1) rd(i << 2, 32'hFFFFFFFF, 32'h0);
    rd(`OFF_FIFO_TEST_CONTROL, 32'hFFFFFFFF, 32'h0);
    rd(12'h03C, 32'h0, 32'h0);
    wr(`OFF_DMA_FIFO_DATA_PORT, 32'h5A);
    rd(`OFF_DMA_FIFO_DATA_PORT, 32'hFF, 32'h0);
    for (l = 0; l < 4; l = l + 1) begin
        wr(`OFF_FIFO_TEST_CONTROL, 32'h4 | l);
        for (i = 0; i < 16; i = i + 1) begin
            d[l*16+i] = $urandom;
            p[l*16+i] = $urandom;
            wr(`OFF_DMA_FIFO_PARITY_WR, {28'h0, p[l*16+i], 3'h0});
            wr(`OFF_DMA_FIFO_DATA_PORT, d[l*16+i]);
        end
        wr(`OFF_DMA_FIFO_DATA_PORT, 32'hEE);
    end
    for (l = 0; l < 4; l = l + 1) begin
        wr(`OFF_FIFO_TEST_CONTROL, 32'h4 | l);
        for (i = 0; i < 16; i = i + 1) begin
            rd(`OFF_DMA_FIFO_DATA_PORT, 32'hFF, d[l*16+i]);
            rd(`OFF_DIAG_STATUS, 32'h8, {28'h0, p[l*16+i], 3'h0});
        end
        wr(`OFF_DMA_FIFO_DATA_PORT, 32'h33);
        rd(`OFF_DMA_FIFO_DATA_PORT, 32'hFF, 32'h33);
    end
    wr(`OFF_FIFO_TEST_CONTROL, 32'h0);
    for (g = 0; g < 3; g = g + 1) begin
        f = $urandom;
        host_parity_lanes_in <= {3'h0, f};
        wr(`OFF_SCSI_CONTROL_FIRST, (g != 0) ? 32'h4 : 32'h0);
        wr(`OFF_SCSI_CONTROL_SECOND, (g == 2) ? 32'h4 : 32'h0);
        wr(`OFF_FIFO_TEST_CONTROL, 32'h08);
        for (i = 0; i < 8; i = i + 1) begin
            d[i] = $urandom;
            wr(`OFF_SCSI_OUTPUT_LATCH, d[i]);
        end
        for (i = 0; i < 8; i = i + 1) begin
            rd(`OFF_SCSI_FIFO_READ_PORT, 32'hFF, d[i]);
            rd(`OFF_DIAG_STATUS, 32'h10,
               {27'h0, (g == 0) ? f : ((g == 2) ? ^d[i] : ~^d[i]), 4'h0});
        end
        wr(`OFF_FIFO_TEST_CONTROL, 32'h0);
    end
    wr(`OFF_SCSI_CONTROL_SECOND, 32'h0);
    for (g = 0; g < 4; g = g + 1) begin
        wr(`OFF_SCSI_CONTROL_FIRST, {28'h0, g[1], g[0], 2'h0});
        x = $urandom;
        host_parity_lanes_in <= x[3:0];
        repeat (4) @(posedge core_clk);
        f = 1'b0;
        for (l = 0; l < 4; l = l + 1) begin
            s = $urandom;
            f = f | (g[1] && (x[l] == ^s[l*8 +: 8]));
            pulse_send(s, l[1:0]);
        end
        host_send_valid <= 1'b0;
        rd(`OFF_SCSI_STATUS_FIRST, 32'h1, {31'h0, f});
        rd(`OFF_SCSI_STATUS_FIRST, 32'h1, 32'h0);
    end
    wr(`OFF_SCSI_CONTROL_FIRST, 32'h8);
    host_parity_lanes_in <= 4'h0;
    for (v = 0; v < 2; v = v + 1) begin
        wr(`OFF_SCSI_IRQ_ENABLE, v);
        pulse_send(32'h0, 2'h0);
        host_send_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        check("parity_irq", parity_irq, v);
        rd(`OFF_SCSI_STATUS_FIRST, 32'h1, 32'h1);
    end
    wr(`OFF_TRANSFER_CONFIG, 32'h80);
    wr(`OFF_SCSI_CONTROL_FIRST, 32'hA);
    for (v = 0; v < 2; v = v + 1) begin
        target_mode <= !v[0];
        repeat (4) @(posedge core_clk);
        scsi_u.send_byte({7'h0, v[0]}, v[0]);
        repeat (4) @(posedge core_clk);
        check("halt_target", halt_target, !v[0]);
        check("scsi_atn_out", scsi_atn_out, v[0]);
        check("host_parity_lanes_out", {28'h0, host_parity_lanes_out}, {28'h0, {4{v[0]}}});
        check("host_parity_lanes_oe", {28'h0, host_parity_lanes_oe}, 32'hF);
        check("scsi_parity_line_oe", {31'h0, scsi_parity_line_oe}, 32'h1);
        rd(`OFF_SCSI_STATUS_THIRD, 32'h8, {28'h0, v[0], 3'h0});
        rd(`OFF_SCSI_STATUS_SECOND, 32'h1, {31'h0, !v[0]});
        rd(`OFF_SCSI_STATUS_FIRST, 32'h1, 32'h1);
        wr(`OFF_TRANSFER_CONFIG, 32'h0);
    end
    wr(`OFF_SCSI_CONTROL_FIRST, 32'h0);
    repeat (5) @(posedge core_clk);
    results;
end
initial begin
    #3000000;
    failures = failures + 1;
    results;
end
endmodule // testbench
